// ### design/ccdr_pkg.sv
// Shared constants and carrier types of the CCD readout serializer
package ccdr_pkg;
  // Clocking: system clock, link bit rate and sequencer step
  localparam int CLK_MHZ = 100;
  localparam int LINK_MBPS = 32;
  localparam int STEP_NS = 125;
  localparam int BITS_PER_STEP = STEP_NS * LINK_MBPS / 1000;
  localparam logic [7:0] ACC_INC = 8'(LINK_MBPS);
  localparam logic [7:0] ACC_MOD = 8'(CLK_MHZ);
  localparam logic [1:0] BCNT_LAST = 2'(BITS_PER_STEP - 1);

  // Analogue settling and conversion windows
  localparam int SETTLE_1PCT_NS = 474;
  localparam int SETTLE_LSB_NS = 766;
  localparam int CONV_ACQ_NS = 250;
  localparam int CONV_MSB_NS = 650;
  localparam int ACQ_STEPS = (CONV_ACQ_NS + STEP_NS - 1) / STEP_NS;
  localparam int MSB_STEPS = CONV_MSB_NS / STEP_NS;

  // Step indices inside one 16-step pixel
  localparam logic [3:0] STEP_RESET = 4'h0;
  localparam logic [3:0] STEP_CLAMP_OFF = 4'h7;
  localparam logic [3:0] STEP_VIDEO = 4'h8;
  localparam logic [3:0] STEP_TRACK = 4'h9;
  localparam logic [3:0] STEP_H3_ON = 4'hc;
  localparam logic [3:0] STEP_STIM_END = 4'hd;
  localparam logic [3:0] STEP_SAMPLE = 4'he;
  localparam logic [3:0] STEP_GUARD = 4'hf;
  localparam logic [3:0] STEP_LOAD = 4'h9;
  localparam logic [3:0] STEP_MSB_END = 4'(STEP_SAMPLE + 4'(MSB_STEPS));

  // Link word layout
  localparam int WORD_BITS = 64;
  localparam int FIELD_BITS = 16;
  localparam int CHAINS = 4;
  localparam logic [6:0] WORD_SHIFTS = 7'(WORD_BITS - 1);
  localparam logic [63:0] EOS_CODE = 64'hfffe_0001_fffe_0001;

  // Register map and fields
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_COUNT = 8'h08;
  localparam logic [4:0] CTRL_RESET = 5'h04;
  localparam int CTRL_TSG = 0;
  localparam int CTRL_STEST = 1;
  localparam int CTRL_LINK = 2;
  localparam int CTRL_NAP = 3;
  localparam int CTRL_STIM = 4;
  localparam int STAT_EOS = 0;
  localparam int STAT_NAP = 1;
  localparam int STAT_RD = 2;
  localparam int STAT_STEP_LSB = 4;

  // Pin synchroniser lanes
  localparam int PIN_RD = 0;
  localparam int PIN_FLUSH = 1;
  localparam int PIN_FRAME = 2;
  localparam int PIN_NAP = 3;

  typedef struct packed {
    logic ccd_rst;
    logic h3;
    logic clamp_n;
    logic iso;
    logic convst_n;
    logic stim_n;
  } ccdr_seq_t;

  localparam ccdr_seq_t SEQ_IDLE = '{ccd_rst: 1'b0, h3: 1'b0,
    clamp_n: 1'b1, iso: 1'b0, convst_n: 1'b1, stim_n: 1'b1};

  typedef struct packed {
    logic [3:0][13:0] smp;
  } ccdr_adc_t;
endpackage

// ### design/ccdr_top.sv
// CCD readout serializer: CDS timing, 64-bit link framing, Wishbone regs
//
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Clamp closes in the same step as the output-node reset pulse.
// - Clamp opens one step before the third horizontal phase falls.
// - ADC sample strobe sits one step before the video phase ends.
// - Isolation switch is tracking before the ADC samples.
// - Reset and video phases are long enough for analogue settling.
// - Converted samples leave on one serial line at 32 Mbps.
// - Each chain gives a 2-bit port id plus its 14-bit sample.
// - Four chain fields form one gapless 64-bit word per pixel.
// - An end-of-sequence word follows every flush and every frame.
// - Local generator drives node reset, h3, clamp, isolation, convert and stimulus alone.
// - A self-test pattern can replace image words on the link.
// - Bias control lines from the digital board pass through.
// - ADC nap control follows the digital board command; the CTRL_NAP bit also forces nap on.
// - The local sequencer steps at 125 ns, derived from the link bit rate.
// - Only the convert strobe toggles (its rise) in the first 250 ns of a conversion.
// - Only clamp opening may toggle after 650 ns of conversion.
module ccdr_top
  import ccdr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  input wire ccdr_adc_t i_adc,
  input wire ccdr_seq_t i_ext_seq,
  input wire logic [7:0] i_bias_ctl,
  input wire logic i_nap_cmd,
  input wire logic i_rd_en,
  input wire logic i_flush_done,
  input wire logic i_frame_done,
  output ccdr_seq_t o_seq,
  output logic [7:0] o_bias_ctl,
  output logic o_adc_nap,
  output logic o_lnk_data,
  output logic o_lnk_word,
  output logic o_lnk_act
);
  typedef struct packed {
    logic [7:0] acc;
    logic [1:0] bcnt;
    logic [4:0] ctrl;
    logic ack;
    logic [31:0] rdat;
    ccdr_adc_t adc_s1;
    ccdr_adc_t adc_s2;
    ccdr_seq_t ext_s1;
    ccdr_seq_t ext_s2;
    ccdr_seq_t seq;
    logic [7:0] bias_s1;
    logic [7:0] bias_s2;
    logic [7:0] bias;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic nap;
    logic [63:0] sr;
    logic [6:0] left;
    logic word;
    logic act;
    logic eos_pend;
    logic [15:0] pat;
    logic [15:0] words;
    logic [15:0] eoss;
  } ccdr_top_st_t;

  ccdr_top_st_t st_q;
  ccdr_top_st_t st_d;

  logic bit_tick;
  logic step_tick;
  logic word_slot;
  logic load_pix;
  logic load_pat;
  logic load_eos;
  logic eos_evt;
  logic wb_req;
  logic [3:0] tsg_step;
  ccdr_seq_t tsg_seq;

  // Chain 0 lands in the top field, so it goes out first
  function automatic logic [63:0] pack_word(input ccdr_adc_t a);
    logic [63:0] w;
    w = '0;
    for (int k = 0; k < CHAINS; k++)
      w[WORD_BITS - 1 - FIELD_BITS * k -: FIELD_BITS] =
        {2'(k), a.smp[k]};
    return w;
  endfunction

  function automatic logic [31:0] reg_read(input logic [7:0] adr,
                                           input ccdr_top_st_t s,
                                           input logic [3:0] step);
    logic [31:0] r;
    r = '0;
    unique case (adr)
      ADR_CTRL:
        r[4:0] = s.ctrl;
      ADR_STATUS:
      begin
        r[STAT_EOS] = s.eos_pend;
        r[STAT_NAP] = s.nap;
        r[STAT_RD] = s.pin_s2[PIN_RD];
        r[STAT_STEP_LSB +: 4] = step;
      end
      ADR_COUNT:
        r = {s.eoss, s.words};
      default:
        r = '0;
    endcase
    return r;
  endfunction

  ccdr_tsg u_tsg (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_step_tick(step_tick),
    .i_stim_en(st_q.ctrl[CTRL_STIM]),
    .o_step(tsg_step),
    .o_seq(tsg_seq)
  );

  // 100 MHz cannot divide to 32 MHz evenly, so a fractional accumulator
  // makes the bit ticks (3 or 4 cycles apart); steps are every 4th bit
  assign bit_tick = st_q.acc >= (ACC_MOD - ACC_INC);
  assign step_tick = bit_tick && (st_q.bcnt == BCNT_LAST);

  // One word slot per pixel: 16 steps of 4 bits carry exactly 64 bits
  assign word_slot = step_tick && (tsg_step == STEP_LOAD);
  assign load_eos = word_slot && st_q.ctrl[CTRL_LINK] && st_q.eos_pend;
  assign load_pat = word_slot && st_q.ctrl[CTRL_LINK] && !st_q.eos_pend
    && st_q.ctrl[CTRL_STEST];
  assign load_pix = word_slot && st_q.ctrl[CTRL_LINK] && !st_q.eos_pend
    && !st_q.ctrl[CTRL_STEST] && st_q.pin_s2[PIN_RD];
  assign eos_evt = (st_q.pin_s2[PIN_FLUSH] && !st_q.pin_s3[PIN_FLUSH]) ||
    (st_q.pin_s2[PIN_FRAME] && !st_q.pin_s3[PIN_FRAME]);
  assign wb_req = i_wb_cyc && i_wb_stb;

  always_comb
  begin
    st_d = st_q;
    st_d.acc = bit_tick ? st_q.acc + ACC_INC - ACC_MOD : st_q.acc + ACC_INC;
    if (bit_tick)
      st_d.bcnt = st_q.bcnt + 2'h1;

    // Two-stage synchronisers for every pin from the other boards
    st_d.adc_s1 = i_adc;
    st_d.adc_s2 = st_q.adc_s1;
    st_d.ext_s1 = i_ext_seq;
    st_d.ext_s2 = st_q.ext_s1;
    st_d.bias_s1 = i_bias_ctl;
    st_d.bias_s2 = st_q.bias_s1;
    st_d.pin_s1 = {i_nap_cmd, i_frame_done, i_flush_done, i_rd_en};
    st_d.pin_s2 = st_q.pin_s1;
    st_d.pin_s3 = st_q.pin_s2;

    st_d.bias = st_q.bias_s2;
    st_d.nap = st_q.pin_s2[PIN_NAP] || st_q.ctrl[CTRL_NAP];
    // External timing is only as clean as the main sequencer makes it
    st_d.seq = st_q.ctrl[CTRL_TSG] ? tsg_seq : st_q.ext_s2;

    // Serializer: shift one bit per link tick, idle low between words
    if (bit_tick)
    begin
      st_d.word = 1'b0;
      if (st_q.left != 7'h00)
      begin
        st_d.sr = {st_q.sr[62:0], 1'b0};
        st_d.left = st_q.left - 7'h01;
      end
      else
      begin
        st_d.sr = '0;
        st_d.act = 1'b0;
      end
    end
    if (load_eos || load_pat || load_pix)
    begin
      st_d.left = WORD_SHIFTS;
      st_d.word = 1'b1;
      st_d.act = 1'b1;
    end
    if (load_eos)
    begin
      st_d.sr = EOS_CODE;
      st_d.eoss = st_q.eoss + 16'h0001;
    end
    if (load_pat)
    begin
      st_d.sr = {st_q.pat, ~st_q.pat, st_q.pat, ~st_q.pat};
      st_d.pat = st_q.pat + 16'h0001;
    end
    if (load_pix)
    begin
      st_d.sr = pack_word(st_q.adc_s2);
      st_d.words = st_q.words + 16'h0001;
    end
    // A flush or frame end in the sending slot is not lost: set wins
    st_d.eos_pend = eos_evt || (st_q.eos_pend && !load_eos);

    // Wishbone classic: ack one cycle after the strobe, write at ack edge
    st_d.ack = wb_req && !st_q.ack;
    if (wb_req && !st_q.ack)
      st_d.rdat = reg_read(i_wb_adr, st_q, tsg_step);
    if (wb_req && st_q.ack && i_wb_we && i_wb_adr == ADR_CTRL && i_wb_sel[0])
      st_d.ctrl = i_wb_dat[4:0];
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_q <= '0;
      st_q.ctrl <= CTRL_RESET;
      st_q.ext_s1 <= SEQ_IDLE;
      st_q.ext_s2 <= SEQ_IDLE;
      st_q.seq <= SEQ_IDLE;
    end
    else
      st_q <= st_d;
  end

  assign o_wb_ack = st_q.ack;
  assign o_wb_dat = st_q.rdat;
  assign o_seq = st_q.seq;
  assign o_bias_ctl = st_q.bias;
  assign o_adc_nap = st_q.nap;
  assign o_lnk_data = st_q.sr[WORD_BITS - 1];
  assign o_lnk_word = st_q.word;
  assign o_lnk_act = st_q.act;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  a_link_bit_rate: assert property (
    bit_tick |=> (!bit_tick) [*2] ##[1:2] bit_tick)
    else $error("link bit spacing is not 3 or 4 cycles");
  a_step_rate: assert property (
    step_tick |=> (!step_tick) [*8] ##[4:5] step_tick)
    else $error("sequencer step is not 125 ns");
  a_settle_time: assert property (
    tsg_step == STEP_SAMPLE |->
    (int'(STEP_SAMPLE) - int'(STEP_VIDEO)) * STEP_NS >= SETTLE_1PCT_NS &&
    int'(STEP_VIDEO) * STEP_NS >= SETTLE_LSB_NS)
    else $error("phase too short for analogue settling");
  a_pixel_word: assert property (
    load_pix |=> st_q.sr == pack_word($past(st_q.adc_s2)) && o_lnk_word)
    else $error("pixel word not packed as four id-sample fields");
  a_eos_follows: assert property (
    eos_evt && st_q.ctrl[CTRL_LINK] |-> ##[1:220] load_eos)
    else $error("end-of-sequence word not sent after flush or frame");
  a_selftest_word: assert property (
    load_pat |=> st_q.sr[63:48] == ~st_q.sr[47:32] && !load_pix)
    else $error("self-test word malformed");
  a_bias_route: assert property (
    $stable(i_bias_ctl) [*4] |-> o_bias_ctl == i_bias_ctl)
    else $error("bias control not passed through");
  a_nap_route: assert property (
    ($stable(i_nap_cmd) && !st_q.ctrl[CTRL_NAP]) [*4] |->
    o_adc_nap == i_nap_cmd)
    else $error("nap control does not follow the command");
  a_local_timing: assert property (
    st_q.ctrl[CTRL_TSG] && $past(st_q.ctrl[CTRL_TSG]) |->
    o_seq == $past(tsg_seq))
    else $error("local generator not driving the switches");

  c_pixel_word: cover property (load_pix);
  c_eos_word: cover property (load_eos);
  c_selftest_word: cover property (load_pat);
  c_external_strobe: cover property (!st_q.ctrl[CTRL_TSG] && !o_seq.convst_n);
endmodule
`default_nettype wire

// ### design/ccdr_tsg.sv
// Local test sequence generator: per-pixel switch and strobe timing
`timescale 1ns/1ns
`default_nettype none
module ccdr_tsg
  import ccdr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_step_tick,
  input wire logic i_stim_en,
  output logic [3:0] o_step,
  output ccdr_seq_t o_seq
);
  typedef struct packed {
    logic [3:0] step;
    ccdr_seq_t seq;
  } ccdr_tsg_st_t;

  ccdr_tsg_st_t st_q;
  ccdr_tsg_st_t st_d;

  function automatic ccdr_seq_t decode(input logic [3:0] s,
                                       input logic stim);
    ccdr_seq_t r;
    r.ccd_rst = (s == STEP_RESET);
    r.clamp_n = (s >= STEP_CLAMP_OFF);
    r.h3 = (s >= STEP_H3_ON) || (s < STEP_VIDEO);
    r.iso = (s < STEP_TRACK);
    r.convst_n = (s != STEP_SAMPLE);
    // Stimulus kept clear of the conversion start edge
    r.stim_n = !(stim && s >= STEP_TRACK && s < STEP_STIM_END);
    return r;
  endfunction

  always_comb
  begin
    st_d = st_q;
    if (i_step_tick)
    begin
      st_d.step = st_q.step + 4'h1;
      st_d.seq = decode(st_d.step, i_stim_en);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_q.step <= STEP_GUARD;
      st_q.seq <= SEQ_IDLE;
    end
    else
      st_q <= st_d;
  end

  assign o_step = st_q.step;
  assign o_seq = st_q.seq;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  a_clamp_with_reset: assert property (
    $rose(o_seq.ccd_rst) |-> $fell(o_seq.clamp_n))
    else $error("clamp did not close with the node reset");
  a_clamp_off_early: assert property (
    $rose(o_seq.clamp_n) |-> ##[12:13] $fell(o_seq.h3))
    else $error("clamp did not open one step before video");
  a_sample_then_reset: assert property (
    $fell(o_seq.convst_n) |-> ##[24:26] $rose(o_seq.ccd_rst))
    else $error("sample not placed ahead of next reset");
  a_track_at_sample: assert property (
    !o_seq.convst_n |-> !o_seq.iso)
    else $error("isolation switch not tracking at sample");
  a_strobe_width: assert property (
    $fell(o_seq.convst_n) |-> (!o_seq.convst_n) [*8] ##[5:6] o_seq.convst_n)
    else $error("convert strobe not one step wide");
  a_quiet_conversion: assert property (
    $changed(o_step) && (o_step == STEP_GUARD ||
      (o_step > STEP_MSB_END && o_step < STEP_VIDEO)) |->
    $stable({o_seq.ccd_rst, o_seq.h3, o_seq.iso, o_seq.stim_n}) &&
    (o_step == STEP_CLAMP_OFF || $stable(o_seq.clamp_n)))
    else $error("switch toggled inside a quiet conversion window");
endmodule
`default_nettype wire

// ### tb/ccdr_icu_model.sv
// Link receiver model: rebuilds 64-bit words from the serial line
`timescale 1ns/1ns
`default_nettype none
module ccdr_icu_model (
  input wire logic i_clk,
  input wire logic i_data,
  input wire logic i_word,
  output logic [63:0] o_word = '0,
  output int o_cnt = 0
);
  logic pw = 1'b0;
  logic pd = 1'b0;
  logic [63:0] sh = '0;
  int n = 0;
  int k = 64;
  // Mid-bit sampling tolerates the 3 or 4 cycle bit jitter
  always @(posedge i_clk)
  begin
    pw <= i_word;
    pd <= i_data;
    n <= n + 1;
    if (k < 64 && n == (100 * (k - 1) + 31) / 32 + 1)
    begin
      sh[63 - k] = i_data;
      k <= k + 1;
      if (k == 63)
      begin
        o_word <= sh;
        o_cnt <= o_cnt + 1;
      end
    end
    if (pw && !i_word)
    begin
      sh[63] = pd;
      n <= 1;
      k <= 1;
    end
  end
endmodule
`default_nettype wire

// ### tb/ccdr_top_tb.sv
// Self-checking bench for the CCD readout serializer top
`timescale 1ns/1ns
`default_nettype none
module ccdr_top_tb;
  import ccdr_pkg::*;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_wb_cyc = 1'b0;
  logic i_wb_stb = 1'b0;
  logic i_wb_we = 1'b0;
  logic [7:0] i_wb_adr = '0;
  logic [3:0] i_wb_sel = '0;
  logic [31:0] i_wb_dat = '0;
  logic o_wb_ack;
  logic [31:0] o_wb_dat;
  ccdr_adc_t i_adc = {14'h0001, 14'h3fff, 14'h0155, 14'h2abc};
  ccdr_seq_t i_ext_seq = SEQ_IDLE;
  logic [7:0] i_bias_ctl = '0;
  logic i_nap_cmd = 1'b0;
  logic i_rd_en = 1'b0;
  logic i_flush_done = 1'b0;
  logic i_frame_done = 1'b0;
  ccdr_seq_t o_seq;
  logic [7:0] o_bias_ctl;
  logic o_adc_nap;
  logic o_lnk_data;
  logic o_lnk_word;
  logic o_lnk_act;
  logic [63:0] rx_word;
  int rx_cnt;
  int err_count = 0;
  int comparisons = 0;

  always #5 i_clk = ~i_clk;

  ccdr_top uut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack),
    .o_wb_dat(o_wb_dat), .i_adc(i_adc), .i_ext_seq(i_ext_seq),
    .i_bias_ctl(i_bias_ctl), .i_nap_cmd(i_nap_cmd), .i_rd_en(i_rd_en),
    .i_flush_done(i_flush_done), .i_frame_done(i_frame_done),
    .o_seq(o_seq), .o_bias_ctl(o_bias_ctl), .o_adc_nap(o_adc_nap),
    .o_lnk_data(o_lnk_data), .o_lnk_word(o_lnk_word),
    .o_lnk_act(o_lnk_act));

  ccdr_icu_model icu (.i_clk(i_clk), .i_data(o_lnk_data),
    .i_word(o_lnk_word), .o_word(rx_word), .o_cnt(rx_cnt));

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge i_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= a;
    i_wb_dat <= d;
    i_wb_sel <= 4'hf;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (o_wb_ack !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      err_count++;
      $display("MISMATCH at %0t: no bus acknowledge", $time);
    end
    q = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  // Cycle count returned lets callers check the word spacing
  task automatic get_word(output logic [63:0] w, output int n);
    int c = rx_cnt;
    n = 0;
    while (rx_cnt == c && n < 700)
    begin
      @(posedge i_clk);
      n++;
    end
    w = rx_word;
  endtask

  // Edge times counted from the convert strobe's falling edge
  task automatic scan(input logic stim);
    int t = 0, tcr = -1, trs = -1, tcf = -1, tcl = -1, th = -1;
    int ns = 0, bad = 0;
    logic isoc;
    ccdr_seq_t p;
    do
    begin
      p = o_seq;
      @(posedge i_clk);
      t++;
    end
    while (!(p.convst_n && !o_seq.convst_n) && t < 400);
    isoc = o_seq.iso;
    for (t = 1; t <= 200; t++)
    begin
      p = o_seq;
      @(posedge i_clk);
      if (!p.convst_n && o_seq.convst_n && tcr < 0)
        tcr = t;
      if (!p.ccd_rst && o_seq.ccd_rst && trs < 0)
        trs = t;
      if (p.clamp_n && !o_seq.clamp_n && tcf < 0)
        tcf = t;
      if (!p.clamp_n && o_seq.clamp_n && tcl < 0)
        tcl = t;
      if (p.h3 && !o_seq.h3 && th < 0)
        th = t;
      ns += int'(!o_seq.stim_n);
      if (t < 25 && p[5:2] != o_seq[5:2])
        bad++;
      if (t > 65 && t < 125 && ({p[5:4], p[2]} != {o_seq[5:4], o_seq[2]}
          || (p.clamp_n && !o_seq.clamp_n)))
        bad++;
    end
    chk(isoc, 1'b0);
    chk(tcr >= 12 && tcr <= 13, 1'b1);
    chk(trs, 25);
    chk(tcf, trs);
    chk(th - tcl >= 12 && th - tcl <= 13, 1'b1);
    chk(tcl - tcf >= 77, 1'b1);
    chk(bad, 0);
    chk(ns, stim ? 50 : 0);
  endtask

  initial
  begin
    logic [31:0] q;
    logic [63:0] w;
    int n;
    int hit;
    repeat (10) @(posedge i_clk);
    i_arst_n <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      i_bias_ctl <= i[0] ? 8'ha5 : 8'h5a;
      // Let the new level land before waiting on the output
      @(posedge i_clk);
      for (n = 0; n < 20 && o_bias_ctl !== i_bias_ctl; n++) @(posedge i_clk);
      chk(o_bias_ctl, i_bias_ctl);
    end
    i_nap_cmd <= 1'b1;
    for (n = 0; n < 20 && o_adc_nap !== 1'b1; n++) @(posedge i_clk);
    wb(1'b0, ADR_STATUS, 32'h0, q);
    chk(q[STAT_NAP], 1'b1);
    i_nap_cmd <= 1'b0;
    for (n = 0; n < 20 && o_adc_nap !== 1'b0; n++) @(posedge i_clk);
    chk(o_adc_nap, 1'b0);
    // External timing passes through; local mode must then ignore it
    i_ext_seq <= 6'h34;
    for (n = 0; n < 40 && o_seq !== 6'h34; n++) @(posedge i_clk);
    chk(o_seq, 6'h34);
    wr(ADR_CTRL, 32'h05);
    scan(1'b0);
    wr(ADR_CTRL, 32'h15);
    scan(1'b1);
    wr(ADR_CTRL, 32'h04);
    i_rd_en <= 1'b1;
    get_word(w, n);
    get_word(w, n);
    chk(w, {2'h0, 14'h2abc, 2'h1, 14'h0155, 2'h2, 14'h3fff, 2'h3,
            14'h0001});
    chk(n, 200);
    chk(o_lnk_act, 1'b1);
    wr(ADR_CTRL, 32'h06);
    get_word(w, n);
    get_word(w, n);
    chk(w[63:48], {48'h0, ~w[47:32]});
    chk(w[31:0], w[63:32]);
    wr(ADR_CTRL, 32'h04);
    for (int ev = 0; ev < 2; ev++)
    begin
      i_flush_done <= (ev == 0);
      i_frame_done <= (ev == 1);
      repeat (10) @(posedge i_clk);
      i_flush_done <= 1'b0;
      i_frame_done <= 1'b0;
      hit = 0;
      repeat (3)
      begin
        get_word(w, n);
        hit += int'(w === EOS_CODE);
      end
      chk(hit, 1);
    end
    wb(1'b0, ADR_COUNT, 32'h0, q);
    chk(q[31:16], 16'h0002);
    // Link off: line must fall idle after the word in flight
    wr(ADR_CTRL, 32'h00);
    repeat (250) @(posedge i_clk);
    chk(o_lnk_act, 1'b0);
    chk(o_lnk_data, 1'b0);
    end_sim();
  end

  initial
  begin
    #200000;
    chk(64'h0, 64'h1);
    end_sim();
  end
endmodule
`default_nettype wire
